// ### mrs_cfg.svh
// Offsets, field positions, reset values and timing counts of the reset sequencer
`ifndef MRS_CFG_SVH
`define MRS_CFG_SVH

// Start-up delay in system clock pulses, and the down-counter reload derived from it
`define MRS_SST_PULSES      1024
`define MRS_SST_RELOAD      11'(`MRS_SST_PULSES - 1)
// Default option-load count; the delay lasts this many system clock pulses plus one
`define MRS_OPT_LOAD_DEF    8'h10

// Register byte offsets on the AXI4-Lite slave
`define MRS_OFS_STATUS      32'h0000_0000
`define MRS_OFS_CTRL        32'h0000_0004
`define MRS_OFS_IRQ_STAT    32'h0000_0008
`define MRS_OFS_IRQ_MASK    32'h0000_000C
`define MRS_ADDR_BITS       4

// Status register field positions
`define MRS_ST_TO_BIT       0
`define MRS_ST_PD_BIT       1
`define MRS_ST_CAUSE_LSB    2
`define MRS_ST_BUSY_BIT     5
// Interrupt event bit positions
`define MRS_EV_CHIP_BIT     0
`define MRS_EV_WARM_BIT     1
`define MRS_EV_WAKE_BIT     2

// Initial register values loaded by a chip reset (never by a warm reset)
`define MRS_INIT_PC         11'h000
`define MRS_INIT_BANK       8'h00
`define MRS_INIT_WATCHDOG_SELECT_REG       8'h07
`define MRS_INIT_INTERRUPT_CONTROL_REG       6'h00
`define MRS_INIT_TIMER_CONTROL_REG       8'h08
`define MRS_INIT_EEPROM_CONTROL_REG       4'h8
`define MRS_INIT_PORT       8'hFF

// Bus responses
`define MRS_RESP_OKAY       2'h0
`define MRS_RESP_SLVERR     2'h2

`endif

// ### mrs_pkg.sv
// Types shared by the reset sequencer
package mrs_pkg;

  // Sequencer states
  typedef enum logic [1:0] {
    MRS_ST_RUN  = 2'b00,
    MRS_ST_HOLD = 2'b01,
    MRS_ST_OPT  = 2'b10,
    MRS_ST_SST  = 2'b11
  } mrs_state_t;

  // Cause of the most recent reset or wake sequence
  typedef enum logic [2:0] {
    MRS_CA_NONE     = 3'b000,
    MRS_CA_POWER    = 3'b001,
    MRS_CA_PIN_RUN  = 3'b010,
    MRS_CA_PIN_HALT = 3'b011,
    MRS_CA_WDT_RUN  = 3'b100,
    MRS_CA_WDT_HALT = 3'b101,
    MRS_CA_WAKE     = 3'b110
  } mrs_cause_t;

  // Whole state of the sequencer
  typedef struct packed {
    logic        pin_meta;
    logic        pin_sync;
    mrs_state_t  state;
    logic [10:0] cnt;
    logic        skip_opt;
    logic        warm;
    mrs_cause_t  cause;
    logic        to_flag;
    logic        pd_flag;
    logic        chip_rst;
    logic        exec_hold;
    logic        wdt_clr;
    logic        warm_pls;
    logic        init_pls;
    logic        pc_pls;
    logic [7:0]  opt_len;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic        irq;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } mrs_regs_t;

endpackage

// ### mrs_reset_seq.sv
// Reset sequencer: reset causes, flags, start-up and option-load delays, AXI4-Lite registers
//
// Operation
// - Chip reset on pin, pin-in-halt, watchdog in run
// - Watchdog time-out in halt gives warm reset
// - Flags per cause: 00, uu, 01, 1u, 11
// - Flags stay readable after any reset
// - 1024-pulse start-up delay after resets, wakes
// - Execution held until start-up delay ends
// - Option-load delay for system resets only
// - Chip reset: PC zero, peripherals to idle
// - Watchdog cleared during chip reset, runs after
// - Chip reset sets stack pointer to top
// - Initial register values except on warm reset
// - Data registers keep contents across resets
// - Ports set to ones except on warm reset
// - Power-down flag cleared, set; time-out cleared
`timescale 1ns/10ps
`include "mrs_cfg.svh"

module mrs_reset_seq
  import mrs_pkg::*;
#(
  parameter int unsigned SST_PULSES = `MRS_SST_PULSES
) (
  // Clock, reset and clock enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              clk_en,
  // Reset pin and cause inputs
  input  wire logic              ext_reset_pin_n,
  input  wire logic              halted,
  input  wire logic              halt_exec,
  input  wire logic              clr_wdt_exec,
  input  wire logic              wdt_timeout,
  input  wire logic              wake_req,
  // Sequencer outputs
  output logic                   chip_reset,
  output logic                   exec_hold,
  output logic                   wdt_clear,
  output logic                   warm_reset,
  output logic                   init_load,
  output logic                   pc_sp_load,
  output logic                   timeout_flag,
  output logic                   powerdown_flag,
  output mrs_pkg::mrs_cause_t    last_cause,
  output logic                   irq,
  // AXI4-Lite write address and data
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  import mrs_pkg::*;

  // Start-up delay reload, at least one pulse
  localparam logic [10:0] SST_RELOAD = 11'(SST_PULSES - 1);

  // Value of the whole state during reset: a power-up sequence starts here
  localparam mrs_regs_t RESET_VAL = '{
    pin_meta:  1'b1,
    pin_sync:  1'b1,
    state:     MRS_ST_OPT,
    cnt:       {3'h0, `MRS_OPT_LOAD_DEF},
    skip_opt:  1'b0,
    warm:      1'b0,
    cause:     MRS_CA_POWER,
    to_flag:   1'b0,
    pd_flag:   1'b0,
    chip_rst:  1'b1,
    exec_hold: 1'b1,
    wdt_clr:   1'b1,
    warm_pls:  1'b0,
    init_pls:  1'b1,
    pc_pls:    1'b1,
    opt_len:   `MRS_OPT_LOAD_DEF,
    irq_stat:  3'h0,
    irq_mask:  3'h0,
    irq:       1'b0,
    awready:   1'b0,
    wready:    1'b0,
    bvalid:    1'b0,
    bresp:     `MRS_RESP_OKAY,
    arready:   1'b0,
    rvalid:    1'b0,
    rresp:     `MRS_RESP_OKAY,
    rdata:     32'h0000_0000
  };

  mrs_regs_t r_q;
  mrs_regs_t r_d;

  // Low address bits of a register word
  function automatic logic [`MRS_ADDR_BITS-1:0] reg_ofs(input logic [31:0] addr);
    reg_ofs = addr[`MRS_ADDR_BITS-1:0];
  endfunction

  // True when an address falls on a mapped register word
  function automatic logic reg_hit(input logic [31:0] addr);
    logic [`MRS_ADDR_BITS-1:0] o;
    o = reg_ofs(addr);
    reg_hit = (addr[31:`MRS_ADDR_BITS] == '0) &&
              ((o == reg_ofs(`MRS_OFS_STATUS))   || (o == reg_ofs(`MRS_OFS_CTRL)) ||
               (o == reg_ofs(`MRS_OFS_IRQ_STAT)) || (o == reg_ofs(`MRS_OFS_IRQ_MASK)));
  endfunction

  // Next-state logic of sequencer, flags and register slave
  always_comb begin
    logic                       pin_low;
    logic [2:0]                 ev;
    logic                       wr_go;
    logic                       rd_go;
    logic [`MRS_ADDR_BITS-1:0]  wofs;
    logic [`MRS_ADDR_BITS-1:0]  rofs;
    pin_low = 1'b0;
    ev      = 3'h0;
    wr_go   = 1'b0;
    rd_go   = 1'b0;
    wofs    = '0;
    rofs    = '0;
    r_d     = r_q;

    // Two-stage synchroniser on the reset pin
    r_d.pin_meta = ext_reset_pin_n;
    r_d.pin_sync = r_q.pin_meta;
    pin_low      = !r_q.pin_sync;

    // One-cycle pulses fall back each cycle
    r_d.warm_pls = 1'b0;
    r_d.init_pls = 1'b0;
    r_d.pc_pls   = 1'b0;

    // Reset sequencer
    case (r_q.state)
      MRS_ST_RUN: begin
        if (pin_low) begin
          // Pin reset, in normal operation or as a wake from halt
          r_d.state    = MRS_ST_HOLD;
          r_d.warm     = 1'b0;
          r_d.init_pls = 1'b1;
          r_d.pc_pls   = 1'b1;
          if (halted) begin
            r_d.to_flag  = 1'b0;
            r_d.pd_flag  = 1'b1;
            r_d.skip_opt = 1'b1;
            r_d.cause    = MRS_CA_PIN_HALT;
          end else begin
            r_d.skip_opt = 1'b0;
            r_d.cause    = MRS_CA_PIN_RUN;
          end
        end else if (wdt_timeout && !halted) begin
          // Watchdog time-out in normal operation: full chip reset
          r_d.state    = MRS_ST_OPT;
          r_d.cnt      = {3'h0, r_q.opt_len};
          r_d.warm     = 1'b0;
          r_d.skip_opt = 1'b0;
          r_d.to_flag  = 1'b1;
          r_d.init_pls = 1'b1;
          r_d.pc_pls   = 1'b1;
          r_d.cause    = MRS_CA_WDT_RUN;
        end else if (wdt_timeout && halted) begin
          // Watchdog time-out in halt: warm reset, PC and SP only
          r_d.state    = MRS_ST_SST;
          r_d.cnt      = SST_RELOAD;
          r_d.warm     = 1'b1;
          r_d.warm_pls = 1'b1;
          r_d.pc_pls   = 1'b1;
          r_d.to_flag  = 1'b1;
          r_d.pd_flag  = 1'b1;
          r_d.cause    = MRS_CA_WDT_HALT;
          ev[`MRS_EV_WARM_BIT] = 1'b1;
        end else if (halted && wake_req) begin
          // Any other wake from halt gets the start-up delay only
          r_d.state = MRS_ST_SST;
          r_d.cnt   = SST_RELOAD;
          r_d.warm  = 1'b1;
          r_d.cause = MRS_CA_WAKE;
        end else begin
          // Instruction effects on the flags; set wins over clear
          if (clr_wdt_exec) begin
            r_d.pd_flag = 1'b0;
          end
          if (halt_exec) begin
            r_d.pd_flag = 1'b1;
            r_d.to_flag = 1'b0;
          end
        end
      end
      MRS_ST_HOLD: begin
        // Stay in reset while the pin is held low
        if (!pin_low) begin
          if (r_q.skip_opt || (r_q.opt_len == 8'h00)) begin
            r_d.state = MRS_ST_SST;
            r_d.cnt   = SST_RELOAD;
          end else begin
            r_d.state = MRS_ST_OPT;
            r_d.cnt   = {3'h0, r_q.opt_len};
          end
        end
      end
      MRS_ST_OPT: begin
        // Option-load delay, then start-up delay
        if (pin_low) begin
          r_d.state    = MRS_ST_HOLD;
          r_d.skip_opt = 1'b0;
          r_d.cause    = MRS_CA_PIN_RUN;
          r_d.init_pls = 1'b1;
          r_d.pc_pls   = 1'b1;
        end else if (r_q.cnt == 11'h000) begin
          r_d.state = MRS_ST_SST;
          r_d.cnt   = SST_RELOAD;
        end else begin
          r_d.cnt = r_q.cnt - 11'h001;
        end
      end
      MRS_ST_SST: begin
        // Start-up delay; execution resumes only at its end
        if (pin_low) begin
          r_d.state    = MRS_ST_HOLD;
          r_d.warm     = 1'b0;
          r_d.init_pls = 1'b1;
          r_d.pc_pls   = 1'b1;
          r_d.skip_opt = r_q.warm && halted;
          r_d.cause    = (r_q.warm && halted) ? MRS_CA_PIN_HALT : MRS_CA_PIN_RUN;
          if (r_q.warm && halted) begin
            r_d.to_flag = 1'b0;
            r_d.pd_flag = 1'b1;
          end
        end else if (r_q.cnt == 11'h000) begin
          r_d.state = MRS_ST_RUN;
          if (r_q.warm) begin
            ev[`MRS_EV_WAKE_BIT] = 1'b1;
          end else begin
            ev[`MRS_EV_CHIP_BIT] = 1'b1;
          end
        end else begin
          r_d.cnt = r_q.cnt - 11'h001;
        end
      end
      default: begin
        r_d.state = MRS_ST_RUN;
      end
    endcase

    // Registered status outputs follow the next state
    r_d.exec_hold = (r_d.state != MRS_ST_RUN);
    r_d.chip_rst  = (r_d.state != MRS_ST_RUN) && !r_d.warm;
    r_d.wdt_clr   = r_d.chip_rst;

    // Write channel: take address and data together, one write at a time
    r_d.awready = 1'b0;
    r_d.wready  = 1'b0;
    if (s_axi_awvalid && s_axi_wvalid && !r_q.awready && !r_q.bvalid) begin
      r_d.awready = 1'b1;
      r_d.wready  = 1'b1;
    end
    wr_go = r_q.awready && s_axi_awvalid && s_axi_wvalid;
    wofs  = reg_ofs(s_axi_awaddr);
    if (wr_go) begin
      r_d.bvalid = 1'b1;
      r_d.bresp  = reg_hit(s_axi_awaddr) ? `MRS_RESP_OKAY : `MRS_RESP_SLVERR;
    end else if (r_q.bvalid && s_axi_bready) begin
      r_d.bvalid = 1'b0;
    end

    // Register writes through byte lane 0
    if (wr_go && s_axi_wstrb[0] && (s_axi_awaddr[31:`MRS_ADDR_BITS] == '0)) begin
      if (wofs == reg_ofs(`MRS_OFS_CTRL)) begin
        r_d.opt_len = s_axi_wdata[7:0];
      end else if (wofs == reg_ofs(`MRS_OFS_IRQ_STAT)) begin
        r_d.irq_stat = r_q.irq_stat & ~s_axi_wdata[2:0];
      end else if (wofs == reg_ofs(`MRS_OFS_IRQ_MASK)) begin
        r_d.irq_mask = s_axi_wdata[2:0];
      end
    end

    // Events set sticky bits after any clear, so a set wins
    r_d.irq_stat = r_d.irq_stat | ev;
    r_d.irq      = |(r_d.irq_stat & r_d.irq_mask);

    // Read channel: one read at a time
    r_d.arready = 1'b0;
    if (s_axi_arvalid && !r_q.arready && !r_q.rvalid) begin
      r_d.arready = 1'b1;
    end
    rd_go = r_q.arready && s_axi_arvalid;
    rofs  = reg_ofs(s_axi_araddr);
    if (rd_go) begin
      r_d.rvalid = 1'b1;
      r_d.rresp  = `MRS_RESP_OKAY;
      r_d.rdata  = 32'h0000_0000;
      if (s_axi_araddr[31:`MRS_ADDR_BITS] != '0) begin
        r_d.rresp = `MRS_RESP_SLVERR;
      end else if (rofs == reg_ofs(`MRS_OFS_STATUS)) begin
        r_d.rdata[`MRS_ST_TO_BIT]                         = r_q.to_flag;
        r_d.rdata[`MRS_ST_PD_BIT]                         = r_q.pd_flag;
        r_d.rdata[`MRS_ST_CAUSE_LSB+2:`MRS_ST_CAUSE_LSB]  = r_q.cause;
        r_d.rdata[`MRS_ST_BUSY_BIT]                       = r_q.exec_hold;
      end else if (rofs == reg_ofs(`MRS_OFS_CTRL)) begin
        r_d.rdata[7:0] = r_q.opt_len;
      end else if (rofs == reg_ofs(`MRS_OFS_IRQ_STAT)) begin
        r_d.rdata[2:0] = r_q.irq_stat;
      end else if (rofs == reg_ofs(`MRS_OFS_IRQ_MASK)) begin
        r_d.rdata[2:0] = r_q.irq_mask;
      end else begin
        r_d.rresp = `MRS_RESP_SLVERR;
      end
    end else if (r_q.rvalid && s_axi_rready) begin
      r_d.rvalid = 1'b0;
    end
  end

  // State register: synchronous reset, frozen while the clock enable is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_q <= RESET_VAL;
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  // Outputs straight from the state register
  assign chip_reset     = r_q.chip_rst;
  assign exec_hold      = r_q.exec_hold;
  assign wdt_clear      = r_q.wdt_clr;
  assign warm_reset     = r_q.warm_pls;
  assign init_load      = r_q.init_pls;
  assign pc_sp_load     = r_q.pc_pls;
  assign timeout_flag   = r_q.to_flag;
  assign powerdown_flag = r_q.pd_flag;
  assign last_cause     = r_q.cause;
  assign irq            = r_q.irq;
  assign s_axi_awready  = r_q.awready;
  assign s_axi_wready   = r_q.wready;
  assign s_axi_bvalid   = r_q.bvalid;
  assign s_axi_bresp    = r_q.bresp;
  assign s_axi_arready  = r_q.arready;
  assign s_axi_rvalid   = r_q.rvalid;
  assign s_axi_rresp    = r_q.rresp;
  assign s_axi_rdata    = r_q.rdata;

endmodule // mrs_reset_seq

// ### mrs_reset_seq_props.sv
// Concurrent checks on the reset sequencer ports
`timescale 1ns/10ps
module mrs_reset_seq_props #(
  parameter int unsigned SST_PULSES = 1024
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Cause inputs
  input wire logic ext_reset_pin_n,
  input wire logic halted,
  input wire logic halt_exec,
  input wire logic clr_wdt_exec,
  input wire logic wdt_timeout,
  // Sequencer outputs
  input wire logic chip_reset,
  input wire logic exec_hold,
  input wire logic wdt_clear,
  input wire logic warm_reset,
  input wire logic init_load,
  input wire logic pc_sp_load,
  input wire logic timeout_flag,
  input wire logic powerdown_flag
);
  logic [15:0] hold_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Length of the current hold in cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) hold_q <= 16'h0000;
    else hold_q <= exec_hold ? hold_q + 16'h0001 : 16'h0000;
  end
  // Pin high long enough to have crossed the synchroniser
  sequence s_pin_idle;
    (ext_reset_pin_n && clk_en)[*3];
  endsequence
  a_wdt_run: assert property (
    s_pin_idle ##0 (wdt_timeout && !halted && !exec_hold) |=> chip_reset && init_load && timeout_flag)
    else $error("watchdog time-out did not start a chip reset");
  a_wdt_warm: assert property (
    s_pin_idle ##0 (wdt_timeout && halted && !exec_hold)
      |=> warm_reset && !init_load && !chip_reset && timeout_flag && powerdown_flag)
    else $error("watchdog wake did not give a warm reset");
  a_halt_pd: assert property (
    s_pin_idle ##0 (halt_exec && !wdt_timeout && !exec_hold) |=> powerdown_flag && !timeout_flag)
    else $error("halt did not set the power-down flag");
  a_clr_pd: assert property (
    s_pin_idle ##0 (clr_wdt_exec && !halt_exec && !wdt_timeout && !exec_hold) |=> !powerdown_flag)
    else $error("clear did not drop the power-down flag");
  a_pin_rst: assert property (
    (!ext_reset_pin_n && clk_en)[*4] |-> chip_reset && exec_hold)
    else $error("held pin did not reset the chip");
  a_chip_init: assert property (
    $rose(chip_reset) |-> init_load && pc_sp_load)
    else $error("chip reset without initial load");
  a_wdt_held: assert property (
    wdt_clear |-> chip_reset && exec_hold)
    else $error("watchdog clear outside a chip reset");
  a_sst_len: assert property (
    $fell(exec_hold) |-> hold_q >= SST_PULSES)
    else $error("execution resumed before the start-up delay");
  a_warm_pulse: assert property (
    warm_reset |=> !warm_reset)
    else $error("warm reset pulse too long");
  a_pwr_flags: assert property (
    $rose(aresetn) |-> !timeout_flag && !powerdown_flag)
    else $error("power-up flags not cleared");
endmodule // mrs_reset_seq_props

// ### mrs_far_model.sv
// Far-side model: reset pin driver and watchdog time-out source
`timescale 1ns/10ps
module mrs_far_model (
  // Clock and watchdog clear
  input  wire logic aclk,
  input  wire logic wdt_clear,
  // Pin and time-out
  output logic      ext_reset_pin_n,
  output logic      wdt_timeout
);
  // Pin released and watchdog quiet at start
  initial begin
    ext_reset_pin_n = 1'b1;
    wdt_timeout = 1'b0;
  end
  // One-cycle overflow; a counter held clear cannot overflow
  task automatic bark();
    int k;
    k = 0;
    @(posedge aclk);
    while (wdt_clear && k < 4000) begin
      @(posedge aclk);
      k++;
    end
    // A counter that never leaves its clear state is a hang
    if (k >= 4000) begin
      tb.err_total++;
      tb.close_out();
    end
    wdt_timeout <= 1'b1;
    @(posedge aclk);
    wdt_timeout <= 1'b0;
    #1;
  endtask
  // Reset request is a low level held on the pin
  task automatic press(input int cycles);
    @(posedge aclk);
    ext_reset_pin_n <= 1'b0;
    repeat (cycles) @(posedge aclk);
    ext_reset_pin_n <= 1'b1;
    #1;
  endtask
endmodule // mrs_far_model

// ### tb.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/10ps
`include "mrs_cfg.svh"
module tb;
  import mrs_pkg::*;
  localparam int STARTUP_DELAY_TIMER = 8;
  // Core side and sequencer signals
  logic        aclk, aresetn, clk_en, halted, ext_reset_pin_n, wdt_timeout, irq;
  logic [2:0]  ev;
  logic        chip_reset, exec_hold, wdt_clear, warm_reset, init_load, pc_sp_load;
  logic        timeout_flag, powerdown_flag;
  mrs_cause_t  last_cause;
  // Register bus
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          err_total, checks_done, n, eto, epd, len;

  mrs_reset_seq #(.SST_PULSES(STARTUP_DELAY_TIMER)) u_mrs_reset_seq (.aclk, .aresetn, .clk_en, .ext_reset_pin_n,
    .halted, .halt_exec(ev[0]), .clr_wdt_exec(ev[1]), .wdt_timeout, .wake_req(ev[2]), .chip_reset,
    .exec_hold, .wdt_clear, .warm_reset, .init_load, .pc_sp_load, .timeout_flag, .powerdown_flag,
    .last_cause, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  mrs_far_model u_far (.aclk, .wdt_clear, .ext_reset_pin_n, .wdt_timeout);

  // Clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Verdict
  task automatic close_out();
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Comparison of one value
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      $display("BAD %s exp %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask
  // Write with paired address and data, then the response
  task automatic wr(input logic [31:0] a, d, output logic [1:0] rs);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (++k > 50) begin err_total++; close_out(); end
    end while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do begin
      @(posedge aclk);
      if (++k > 50) begin err_total++; close_out(); end
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    #1;
  endtask
  // Read with address handshake, then the data
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (++k > 50) begin err_total++; close_out(); end
    end while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      if (++k > 50) begin err_total++; close_out(); end
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    #1;
  endtask
  // Cycles until execution resumes
  task automatic wait_run(output int c);
    c = 0;
    while (exec_hold !== 1'b0) begin
      @(posedge aclk);
      #1;
      if (++c > 3000) begin err_total++; close_out(); end
    end
  endtask
  // One-cycle core event: 0 halt, 1 watchdog clear, 2 wake
  task automatic pulse(input int b);
    @(posedge aclk);
    ev[b] <= 1'b1;
    @(posedge aclk);
    ev <= 3'b000;
    #1;
  endtask
  // Flags and cause against the reference, on the pins and in the status word
  task automatic flags(input mrs_cause_t c);
    chk("timeout_flag", 32'(timeout_flag), 32'(eto));
    chk("powerdown_flag", 32'(powerdown_flag), 32'(epd));
    chk("last_cause", 32'(last_cause), 32'(c));
    rd(`MRS_OFS_STATUS, v, r);
    chk("status", v, {26'h0, 1'b0, c, epd[0], eto[0]});
  endtask

  // Main sequence
  initial begin
    {aresetn, halted, ev, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    clk_en = 1'b1;
    s_axi_wstrb = 4'hF;
    {err_total, checks_done, eto, epd} = '0;
    n = $urandom(16);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    wait_run(n);
    chk("power_len", n, int'(`MRS_OPT_LOAD_DEF) + 1 + STARTUP_DELAY_TIMER);
    flags(MRS_CA_POWER);
    rd(`MRS_OFS_CTRL, v, r);
    chk("ctrl_init", v, 32'h0000_0010);
    rd(32'h0000_0010, v, r);
    chk("bad_addr", {v[29:0], r}, 32'(`MRS_RESP_SLVERR));
    len = $urandom_range(20, 1);
    wr(`MRS_OFS_CTRL, 32'(len), r);
    chk("wr_resp", 32'(r), 32'(`MRS_RESP_OKAY));
    wr(32'h0000_0010, 32'h0000_0000, r);
    chk("wr_bad", 32'(r), 32'(`MRS_RESP_SLVERR));
    rd(`MRS_OFS_CTRL, v, r);
    chk("ctrl_back", v, 32'(len));
    wr(`MRS_OFS_IRQ_STAT, 32'h7, r);
    wr(`MRS_OFS_IRQ_MASK, 32'h0, r);
    // Watchdog time-out in normal operation
    u_far.bark();
    eto = 1;
    chk("wdt_loads", 32'({chip_reset, wdt_clear, init_load, pc_sp_load, warm_reset}), 32'h1E);
    wait_run(n);
    chk("wdt_len", n, len + 1 + STARTUP_DELAY_TIMER);
    flags(MRS_CA_WDT_RUN);
    rd(`MRS_OFS_IRQ_STAT, v, r);
    chk("irq_stat", v, 32'h1);
    chk("irq_masked", 32'(irq), 32'h0);
    wr(`MRS_OFS_IRQ_MASK, 32'h1, r);
    repeat (2) @(posedge aclk);
    #1;
    chk("irq_on", 32'(irq), 32'h1);
    wr(`MRS_OFS_IRQ_STAT, 32'h1, r);
    repeat (2) @(posedge aclk);
    #1;
    chk("irq_off", 32'(irq), 32'h0);
    // Halt, then a watchdog wake gives a warm reset
    pulse(0);
    {eto, epd} = {32'd0, 32'd1};
    flags(MRS_CA_WDT_RUN);
    halted <= 1'b1;
    u_far.bark();
    halted <= 1'b0;
    chk("warm_loads", 32'({chip_reset, wdt_clear, init_load, pc_sp_load, warm_reset}), 32'h3);
    eto = 1;
    wait_run(n);
    chk("warm_len", n, STARTUP_DELAY_TIMER);
    flags(MRS_CA_WDT_HALT);
    pulse(1);
    epd = 0;
    flags(MRS_CA_WDT_HALT);
    // Pin reset in normal operation keeps both flags
    u_far.press(6);
    chk("pin_chip", 32'(chip_reset), 32'h1);
    wait_run(n);
    flags(MRS_CA_PIN_RUN);
    // Pin reset while halted
    pulse(0);
    {eto, epd} = {32'd0, 32'd1};
    halted <= 1'b1;
    u_far.press(6);
    halted <= 1'b0;
    wait_run(n);
    flags(MRS_CA_PIN_HALT);
    // Plain wake from halt
    pulse(0);
    halted <= 1'b1;
    pulse(2);
    halted <= 1'b0;
    chk("wake_loads", 32'({chip_reset, wdt_clear, init_load, pc_sp_load, warm_reset}), 32'h0);
    // Clock enable low freezes the start-up count, so the length seen after it is unchanged
    clk_en <= 1'b0;
    repeat (5) @(posedge aclk);
    clk_en <= 1'b1;
    wait_run(n);
    chk("wake_len", n, STARTUP_DELAY_TIMER);
    flags(MRS_CA_WAKE);
    close_out();
  end
endmodule // tb

bind mrs_reset_seq mrs_reset_seq_props #(.SST_PULSES(SST_PULSES)) u_props (.aclk, .aresetn, .clk_en,
  .ext_reset_pin_n, .halted, .halt_exec, .clr_wdt_exec, .wdt_timeout, .chip_reset, .exec_hold,
  .wdt_clear, .warm_reset, .init_load, .pc_sp_load, .timeout_flag, .powerdown_flag);
